// ### verilog/dbs_lane_steer.sv
// top: splits operands into bus cycles, steers lanes, sizes the data bus
// Notes on behaviour
// RULE1: low address bits from lowest asserted lane
// RULE2: coprocessor cycles: io space, top bit high
// RULE3: memory 32-bit range, io 16-bit range
// RULE4: lowest address byte on lowest lane
// RULE5: half-width select sampled every bus cycle
// RULE6: half-width splits wide or misaligned operands
// RULE7: half-width cycles move bytes on lower half
// RULE8: lower-lanes-only cycle unaffected by half-width
// RULE9: upper-only read half-width: take lower half
// RULE10: upper-only write always mirrors upper onto lower
// RULE11: spanning read half-width: two cycles, low first
// RULE12: second split cycle negates lanes 0 and 1
// RULE13: spanning write: all bytes first, mirror second
// RULE14: port holds half-width during second write
// RULE15: decoder asserts half-width only for narrow arrays
// RULE16: pipelined decoders also use lanes and write
// RULE17: port decoder makes half bit and strobes
// RULE18: never empty or non-contiguous lanes
// RULE19: multiple cycles when alignment or width requires
// RULE20: high bytes first; half-width split low first
// RULE21: full-width memory uses dword address lines
// RULE22: port decoder purely combinational
`timescale 1ns/1ps
module dbs_lane_steer #(
    parameter int unsigned FIFO_DEPTH = dbs_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire dbs_pkg::dbs_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    output dbs_pkg::dbs_rsp_t rsp,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic bus_start,
    output logic [29:0] doubleword_address_lines,
    output logic [3:0] byte_lane_selects_n,
    output logic write_not_read,
    output logic mem_not_io,
    output logic word_half_address_bit,
    output logic odd_byte_address_bit,
    input wire logic [31:0] data_in,
    output logic [31:0] data_out,
    output logic [31:0] data_oe_n,
    input wire logic bus_done_n,
    input wire logic half_width_bus_select_n
);
    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("dbs_lane_steer fifo depth too small");
        end
    end

    localparam int unsigned REQ_W = $bits(dbs_pkg::dbs_req_t);
    localparam int unsigned RSP_W = $bits(dbs_pkg::dbs_rsp_t);

    // pin inputs pass two flops before use
    logic done_s1_r;
    logic done_s2_r;
    logic hw_s1_r;
    logic hw_s2_r;
    // read data rides the same two flops as the done pin
    logic [31:0] din_s1_r;
    logic [31:0] din_s2_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            done_s1_r <= 1'b1;
            done_s2_r <= 1'b1;
            hw_s1_r <= 1'b1;
            hw_s2_r <= 1'b1;
            din_s1_r <= '0;
            din_s2_r <= '0;
        end else begin
            done_s1_r <= bus_done_n;
            done_s2_r <= done_s1_r;
            hw_s1_r <= half_width_bus_select_n;
            hw_s2_r <= hw_s1_r;
            din_s1_r <= data_in;
            din_s2_r <= din_s1_r;
        end
    end
    logic bus_done;
    logic half_width;
    assign bus_done = !done_s2_r;
    assign half_width = !hw_s2_r;

    // completed operands queue toward the core
    logic [RSP_W-1:0] rsp_bits;
    logic rsp_push;
    logic rsp_room;
    dbs_fifo #(
        .WIDTH(RSP_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rsp_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_data(rsp_bits),
        .in_valid(rsp_push),
        .in_ready(rsp_room),
        .out_data(rsp),
        .out_valid(rsp_valid),
        .out_ready(rsp_ready)
    );

    dbs_pkg::dbs_state_t state_r;
    dbs_pkg::dbs_req_t op_r;
    logic [32:0] cur_addr_r;
    logic [2:0] left_r;
    logic [3:0] pend_lanes_r;
    logic second_half_r;
    logic [31:0] rdata_r;
    logic [2:0] shift_r;
    dbs_pkg::dbs_cyc_t cyc_r;

    // lanes of the bytes still due in the current dword, high bytes first
    logic [1:0] off;
    logic [2:0] fit;
    logic [2:0] take;
    logic [3:0] first_lanes;
    logic [32:0] start_addr;
    always_comb begin
        off = cur_addr_r[1:0];
        fit = 3'd4 - {1'b0, off};
        take = (left_r < fit) ? left_r : fit;
        unique case (take)
            3'd1: first_lanes = 4'h1 << off;
            3'd2: first_lanes = 4'h3 << off;
            3'd3: first_lanes = 4'h7 << off;
            default: first_lanes = 4'hf << off;
        endcase
    end

    // operand start: io space folds to 16 bits, coprocessor lands high
    always_comb begin
        if (req.coproc) begin
            start_addr = {1'b0, dbs_pkg::COPROC_BASE | {29'h0, req.addr[2:0]}}; // [RULE2]
        end else if (req.is_io) begin
            start_addr = {17'h0, req.addr[15:0]}; // [RULE3]
        end else begin
            start_addr = {1'b0, req.addr}; // [RULE3]
        end
    end

    logic [2:0] op_bytes;
    always_comb begin
        unique case (req.size)
            dbs_pkg::OP_BYTE: op_bytes = 3'd1;
            dbs_pkg::OP_WORD: op_bytes = 3'd2;
            default: op_bytes = 3'd4;
        endcase
    end

    // pieces crossing a dword go high piece first: start from the top dword
    logic [32:0] end_addr;
    logic [32:0] hi_addr;
    logic crosses;
    always_comb begin
        end_addr = start_addr + 33'(op_bytes) - 33'd1;
        crosses = end_addr[32:2] != start_addr[32:2];
        hi_addr = crosses ? {end_addr[32:2], 2'b00} : start_addr;
    end

    logic upper_only;
    logic spans;
    logic split_now;
    always_comb begin
        upper_only = (pend_lanes_r & dbs_pkg::LANES_LOW) == dbs_pkg::LANES_NONE;
        spans = !upper_only && ((pend_lanes_r & dbs_pkg::LANES_HIGH) != dbs_pkg::LANES_NONE);
        split_now = half_width && spans && !second_half_r; // [RULE5] [RULE6] [RULE11]
    end

    assign req_ready = (state_r == dbs_pkg::DBS_IDLE);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= dbs_pkg::DBS_IDLE;
            op_r <= '0;
            cur_addr_r <= '0;
            left_r <= 3'd0;
            pend_lanes_r <= 4'h0;
            second_half_r <= 1'b0;
            shift_r <= 3'd0;
            cyc_r <= '0;
        end else begin
            unique case (state_r)
                dbs_pkg::DBS_IDLE: begin
                    if (req_valid) begin
                        op_r <= req;
                        second_half_r <= 1'b0;
                        // high dword first; remaining low piece later [RULE19] [RULE20]
                        cur_addr_r <= hi_addr;
                        left_r <= crosses ? 3'(end_addr[1:0]) + 3'd1 : op_bytes;
                        shift_r <= crosses ? op_bytes - (3'(end_addr[1:0]) + 3'd1) : 3'd0;
                        state_r <= dbs_pkg::DBS_ISSUE;
                    end
                end
                dbs_pkg::DBS_ISSUE: begin
                    pend_lanes_r <= second_half_r ? pend_lanes_r : first_lanes; // [RULE18]
                    cyc_r.dword_addr <= cur_addr_r[31:2]; // [RULE21]
                    cyc_r.lanes <= second_half_r ? (pend_lanes_r & dbs_pkg::LANES_HIGH)
                                                 : first_lanes; // [RULE12]
                    cyc_r.write <= op_r.write;
                    cyc_r.mem_io <= !(op_r.is_io || op_r.coproc);
                    state_r <= dbs_pkg::DBS_WAIT;
                end
                dbs_pkg::DBS_WAIT: begin
                    if (bus_done) begin
                        if (split_now) begin
                            // low half done, rerun upper lanes only [RULE11] [RULE20]
                            second_half_r <= 1'b1;
                            state_r <= dbs_pkg::DBS_ISSUE;
                        end else begin
                            second_half_r <= 1'b0;
                            if (left_r == 3'd0 || shift_r == 3'd0) begin
                                state_r <= dbs_pkg::DBS_DONE;
                            end else begin
                                // low-order remainder in the dword below
                                cur_addr_r <= {cur_addr_r[32:2] - 31'd1, 2'b00} +
                                              33'(3'd4 - shift_r);
                                left_r <= shift_r;
                                shift_r <= 3'd0;
                                state_r <= dbs_pkg::DBS_ISSUE;
                            end
                        end
                    end
                end
                dbs_pkg::DBS_DONE: begin
                    if (rsp_room) begin
                        state_r <= dbs_pkg::DBS_IDLE;
                    end
                end
                default: state_r <= dbs_pkg::DBS_IDLE;
            endcase
        end
    end

    // gather read bytes into operand order; steered from lower half if narrow
    logic [31:0] steered;
    logic [3:0] live_lanes;
    always_comb begin
        live_lanes = cyc_r.lanes;
        steered = din_s2_r;
        if (half_width && !upper_only) begin
            steered[31:16] = din_s2_r[15:0]; // [RULE11]
        end
        if (half_width && (upper_only || second_half_r)) begin
            steered[31:16] = din_s2_r[15:0]; // [RULE9]
        end
        if (split_now) begin
            live_lanes = cyc_r.lanes & dbs_pkg::LANES_LOW; // [RULE8]
        end
    end

    logic [4:0] base_byte;
    always_comb begin
        // operand byte index of lane 0 in this dword
        base_byte = 5'({cur_addr_r[32:2], 2'b00} - start_of_op());
    end

    function automatic logic [32:0] start_of_op();
        logic [32:0] s;
        s = {1'b0, op_r.addr};
        if (op_r.coproc) begin
            s = {1'b0, dbs_pkg::COPROC_BASE | {29'h0, op_r.addr[2:0]}};
        end else if (op_r.is_io) begin
            s = {17'h0, op_r.addr[15:0]};
        end
        return s;
    endfunction

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (state_r == dbs_pkg::DBS_IDLE && req_valid) begin
            rdata_r <= '0;
        end else if (state_r == dbs_pkg::DBS_WAIT && bus_done && !op_r.write) begin
            for (int i = 0; i < 4; i++) begin
                if (live_lanes[i]) begin
                    rdata_r[8*int'(2'(5'(i) + base_byte)) +: 8] <= steered[8*i +: 8]; // [RULE4]
                end
            end
        end
    end

    // write data aligned to lanes; upper half mirrored as needed
    logic [31:0] lane_wdata;
    always_comb begin
        if (base_byte[4]) begin
            lane_wdata = op_r.wdata << (8 * 5'(5'd0 - base_byte));
        end else begin
            lane_wdata = op_r.wdata >> (8 * base_byte);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            data_out <= '0;
        end else if (state_r == dbs_pkg::DBS_ISSUE) begin
            data_out <= lane_wdata; // [RULE4] [RULE13]
            if (second_half_r || upper_only_next()) begin
                data_out[15:0] <= lane_wdata[31:16]; // [RULE10] [RULE13] [RULE7]
            end
        end
    end

    function automatic logic upper_only_next();
        logic [3:0] l;
        l = second_half_r ? (pend_lanes_r & dbs_pkg::LANES_HIGH) : first_lanes;
        return (l & dbs_pkg::LANES_LOW) == dbs_pkg::LANES_NONE;
    endfunction

    // bus pin drive
    logic in_cycle;
    assign in_cycle = (state_r == dbs_pkg::DBS_WAIT);
    // address strobe: first clock of each bus cycle
    logic issued_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            issued_r <= 1'b0;
        end else begin
            issued_r <= (state_r == dbs_pkg::DBS_ISSUE);
        end
    end
    assign bus_start = in_cycle && issued_r;
    assign doubleword_address_lines = cyc_r.dword_addr;
    assign byte_lane_selects_n = in_cycle ? ~cyc_r.lanes : 4'hf;
    assign write_not_read = cyc_r.write;
    assign mem_not_io = cyc_r.mem_io;
    assign data_oe_n = (in_cycle && cyc_r.write) ? 32'h0 : 32'hffffffff;

    // base address bits from lowest selected lane
    always_comb begin
        word_half_address_bit = !(cyc_r.lanes[0] || cyc_r.lanes[1]); // [RULE1]
        odd_byte_address_bit = !cyc_r.lanes[0] && (cyc_r.lanes[1] || !cyc_r.lanes[2]); // [RULE1]
    end

    assign rsp_bits = {rdata_r, op_r.write};
    assign rsp_push = (state_r == dbs_pkg::DBS_DONE) && rsp_room;
endmodule

// ### verilog/dbs_pkg.sv
// package: shared types and constants for the bus sizing lane steer block
package dbs_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned LANES = 4;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned IO_ADDR_W = 16;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam logic [31:0] COPROC_BASE = 32'h800000f8;
    localparam logic [31:0] COPROC_LAST = 32'h800000ff;
    localparam logic [3:0] LANES_NONE = 4'h0;
    localparam logic [3:0] LANES_LOW = 4'h3;
    localparam logic [3:0] LANES_HIGH = 4'hc;
    localparam logic [1:0] OP_BYTE = 2'h0;
    localparam logic [1:0] OP_WORD = 2'h1;
    localparam logic [1:0] OP_DWORD = 2'h3;

    // one operand request from the core side
    typedef struct packed {
        logic write;
        logic is_io;
        logic coproc;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dbs_req_t;

    // one completed operand back to the core side
    typedef struct packed {
        logic [31:0] rdata;
        logic write;
    } dbs_rsp_t;

    // bus cycle definition driven toward the ports
    typedef struct packed {
        logic [29:0] dword_addr;
        logic [3:0] lanes;
        logic write;
        logic mem_io;
        logic [31:0] wdata;
    } dbs_cyc_t;

    typedef enum logic [1:0] {
        DBS_IDLE,
        DBS_ISSUE,
        DBS_WAIT,
        DBS_DONE
    } dbs_state_t;
endpackage

// ### verilog/dbs_fifo.sv
// fifo: parameterised width and depth, valid/ready on both ends
`timescale 1ns/1ps
module dbs_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("dbs_fifo depth must be a power of two, at least 2");
        end
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic push;
    logic pop;
    assign in_ready = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr_r != rd_ptr_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + (AW+1)'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + (AW+1)'(1);
            end
        end
    end
endmodule

// ### tb/dbs_lane_steer_asserts.sv
// checker: cycle shape, lane decode and half-width split
`timescale 1ns/1ps
module dbs_lane_steer_asserts (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic req_ready,
    input wire logic [29:0] doubleword_address_lines,
    input wire logic [3:0] byte_lane_selects_n,
    input wire logic write_not_read,
    input wire logic mem_not_io,
    input wire logic word_half_address_bit,
    input wire logic odd_byte_address_bit,
    input wire logic [31:0] data_out,
    input wire logic [31:0] data_oe_n,
    input wire logic bus_done_n,
    input wire logic half_width_bus_select_n,
    input wire logic bus_start
);
    logic act, wr, io;
    logic [3:0] ln;
    logic [29:0] da;
    assign ln = byte_lane_selects_n;
    assign da = doubleword_address_lines;
    assign act = ln != 4'hf;
    assign wr = act && write_not_read;
    assign io = act && !mem_not_io;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_span_end;
        act && ln[2:1] == 2'h0 && !half_width_bus_select_n && !bus_done_n;
    endsequence
    sequence s_upper;
        act && ln[1:0] == 2'h3;
    endsequence
    property p_split; s_span_end |-> ##[1:12] s_upper; endproperty
    property p_contig;
        act |-> ln inside {4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h9, 4'h3, 4'h8, 4'h1, 4'h0};
    endproperty
    property p_odd; act |-> odd_byte_address_bit == (ln[0] && (!ln[1] || ln[2])); endproperty
    property p_half; act |-> word_half_address_bit == (ln[1:0] == 2'h3); endproperty
    property p_cop; io && da[29] |-> da[28:1] == 28'h000001f; endproperty
    property p_io; io && !da[29] |-> da[29:14] == 16'h0000; endproperty
    property p_mirror;
        wr && ln[1:0] == 2'h3 |-> data_out[15:0] == data_out[31:16] && data_oe_n[15:0] == 16'h0;
    endproperty
    property p_span_wr; wr && ln[2:1] == 2'h0 |-> data_oe_n == 32'h0; endproperty
    property p_rd; act && !write_not_read |-> data_oe_n == 32'hffffffff; endproperty
    property p_busy; act |-> !req_ready; endproperty
    property p_start; bus_start == $rose(act); endproperty
    a_split: assert property (p_split) else $error("no upper half cycle");
    a_contig: assert property (p_contig) else $error("bad lane pattern");
    a_odd: assert property (p_odd) else $error("odd byte bit wrong");
    a_half: assert property (p_half) else $error("word half bit wrong");
    a_cop: assert property (p_cop) else $error("coprocessor address wrong");
    a_io: assert property (p_io) else $error("io address too wide");
    a_mirror: assert property (p_mirror) else $error("upper half not mirrored");
    a_span_wr: assert property (p_span_wr) else $error("span write not driven");
    a_rd: assert property (p_rd) else $error("driving during read");
    a_busy: assert property (p_busy) else $error("ready during cycle");
    a_start: assert property (p_start) else $error("strobe not on first clock");
endmodule
bind dbs_lane_steer dbs_lane_steer_asserts u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .req_ready(req_ready), .doubleword_address_lines(doubleword_address_lines),
    .byte_lane_selects_n(byte_lane_selects_n), .write_not_read(write_not_read),
    .mem_not_io(mem_not_io), .word_half_address_bit(word_half_address_bit),
    .odd_byte_address_bit(odd_byte_address_bit), .data_out(data_out), .data_oe_n(data_oe_n),
    .bus_done_n(bus_done_n), .half_width_bus_select_n(half_width_bus_select_n),
    .bus_start(bus_start));

// ### tb/dbs_port_model.sv
// partner: 32-bit and 16-bit ports with their address decoder
`timescale 1ns/1ps
module dbs_port_model (
    input wire logic ref_clk,
    input wire logic slow,
    input wire logic [29:0] dwa,
    input wire logic [3:0] lanes_n,
    input wire logic wnr,
    input wire logic [31:0] dout,
    output logic [31:0] din,
    output logic done_n,
    output logic half_n
);
    logic [7:0] mem [logic [31:0]];
    logic act, narrow, hi;
    logic [31:0] b;
    assign act = lanes_n != 4'hf;
    assign narrow = dwa[16];
    assign hi = lanes_n[1:0] == 2'h3;
    assign b = {dwa, 2'h0} + ((narrow && hi) ? 32'h2 : 32'h0);
    assign half_n = !(act && narrow);
    function automatic logic [7:0] mb(input logic [31:0] a);
        return mem.exists(a) ? mem[a] : (a[7:0] ^ 8'h5a);
    endfunction
    // upper half of a narrow port floats: show its inverse
    initial begin
        din = 32'h0;
        forever begin
            @(posedge ref_clk);
            #1 din = ~din;
            if (act && !wnr && narrow) din = {~{mb(b + 1), mb(b)}, mb(b + 1), mb(b)};
            if (act && !wnr && !narrow) din = {mb(b + 3), mb(b + 2), mb(b + 1), mb(b)};
        end
    end
    initial begin
        done_n = 1'b1;
        forever begin
            @(posedge ref_clk);
            if (act) begin
                repeat (slow ? 4 : 0) @(posedge ref_clk);
                if (wnr && narrow) begin
                    if (!lanes_n[hi ? 2 : 0]) mem[b] = dout[7:0];
                    if (!lanes_n[hi ? 3 : 1]) mem[b + 1] = dout[15:8];
                end
                for (int i = 0; i < 4; i++) begin
                    if (wnr && !narrow && !lanes_n[i]) mem[b + i] = dout[8*i+:8];
                end
                #1 done_n = 1'b0;
                @(posedge ref_clk);
                #1 done_n = 1'b1;
                repeat (5) @(posedge ref_clk);
            end
        end
    end
endmodule

// ### tb/testbench.sv
// testbench: operand splitting, lane steering and bus sizing
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
    logic ref_clk, rst_n, req_valid, req_ready, rsp_valid, rsp_ready, bus_start;
    logic wnr, mio, half_bit, odd_bit, done_n, half_n, slow;
    dbs_pkg::dbs_req_t req;
    dbs_pkg::dbs_rsp_t rsp;
    logic [29:0] dwa;
    logic [3:0] lanes_n;
    logic [31:0] din, dout, oe_n;
    logic [34:0] seen [$];
    logic [34:0] last;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    dbs_lane_steer DUT (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .rsp(rsp), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .bus_start(bus_start), .doubleword_address_lines(dwa), .byte_lane_selects_n(lanes_n),
        .write_not_read(wnr), .mem_not_io(mio), .word_half_address_bit(half_bit),
        .odd_byte_address_bit(odd_bit), .data_in(din), .data_out(dout), .data_oe_n(oe_n),
        .bus_done_n(done_n), .half_width_bus_select_n(half_n));
    dbs_port_model u_port (.ref_clk(ref_clk), .slow(slow), .dwa(dwa), .lanes_n(lanes_n),
        .wnr(wnr), .dout(dout), .din(din), .done_n(done_n), .half_n(half_n));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // log each new bus cycle as {memory, address, lanes}
    always @(posedge ref_clk) begin
        cyc++;
        if (lanes_n != 4'hf && {mio, dwa, lanes_n} != last) seen.push_back({mio, dwa, lanes_n});
        last = {mio, dwa, lanes_n};
        if (cyc > 20000) begin
            error_cnt++;
            final_report();
        end
    end
    function automatic logic [31:0] pat(input logic [31:0] a, input int n);
        pat = 32'h0;
        for (int i = 0; i < n; i++) pat[8*i+:8] = 8'(a + 32'(i)) ^ 8'h5a;
    endfunction
    function automatic logic [31:0] msk(input logic [1:0] sz);
        return (sz == 2'h0) ? 32'hff : ((sz == 2'h1) ? 32'hffff : 32'hffffffff);
    endfunction
    task automatic put(input logic w, io, cp, input logic [1:0] sz, input logic [31:0] a, d);
        int n;
        n = 0;
        @(posedge ref_clk);
        #1 req = '{write: w, is_io: io, coproc: cp, size: sz, addr: a, wdata: d};
        req_valid = 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 100);
        #1 req_valid = 1'b0;
    endtask
    task automatic get(output logic [31:0] q);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 200);
        `CHK("rsp_valid", 1'b1, rsp_valid)
        q = rsp.rdata;
    endtask
    task automatic op(input logic w, io, cp, input logic [1:0] sz, input logic [31:0] a, d,
                      output logic [31:0] q);
        put(w, io, cp, sz, a, d);
        get(q);
    endtask
    task automatic t_sizes();
        logic [31:0] a, q, d;
        logic [1:0] sz;
        for (int k = 0; k < 24; k++) begin
            sz = (k % 3 == 2) ? 2'h3 : 2'(k % 3);
            a = ((k / 12) ? 32'h41000 : 32'h1000) + 32'(k * 8 + k % 4);
            d = {4{8'(k)}} ^ 32'ha1b2c3d4;
            #1 slow = 1'(k % 2);
            op(0, 0, 0, sz, a + 32'h100, 0, q);
            `CHK("read", pat(a + 32'h100, int'(sz) + 1), q & msk(sz))
            op(1, 0, 0, sz, a, d, q);
            op(0, 0, 0, sz, a, 0, q);
            `CHK("readback", d & msk(sz), q & msk(sz))
        end
    endtask
    task automatic t_cyc(input logic [31:0] a, input logic [1:0] sz, input int n,
                         input logic [29:0] d0, d1, input logic [3:0] l0, l1);
        logic [31:0] q;
        seen.delete();
        op(0, 0, 0, sz, a, 0, q);
        `CHK("cycles", n, seen.size())
        `CHK("first", {1'b1, d0, l0}, seen[0])
        if (n > 1) `CHK("second", {1'b1, d1, l1}, seen[1])
        `CHK("data", pat(a, int'(sz) + 1), q & msk(sz))
    endtask
    task automatic t_space();
        logic [31:0] q;
        seen.delete();
        op(0, 1, 1, 2'h0, 32'h3, 0, q);
        `CHK("coproc", {1'b0, 30'h2000003e, 4'h7}, seen[0])
        seen.delete();
        op(1, 1, 0, 2'h1, 32'h00ab1236, 32'h5a5a, q);
        `CHK("io", {1'b0, 30'h48d, 4'h3}, seen[0])
    endtask
    task automatic t_fifo();
        logic [31:0] q;
        int n;
        n = 0;
        #1 rsp_ready = 1'b0;
        for (int i = 0; i < 17; i++) put(0, 0, 0, 2'h3, 32'h3000 + 32'(i * 4), 0);
        repeat (40) @(posedge ref_clk) n += int'(req_ready === 1'b1);
        `CHK("ready_full", 0, n)
        #1 rsp_ready = 1'b1;
        for (int i = 0; i < 17; i++) begin
            get(q);
            `CHK("fifo_data", pat(32'h3000 + 32'(i * 4), 4), q)
        end
    endtask
    task automatic final_report();
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        rsp_ready = 1'b1;
        slow = 1'b0;
        repeat (4) @(posedge ref_clk);
        `CHK("idle_lanes", 4'hf, lanes_n)
        `CHK("idle_oe", 32'hffffffff, oe_n)
        `CHK("idle_data", 32'h0, dout)
        `CHK("start", 1'b0, bus_start)
        #1 rst_n = 1'b1;
        t_sizes();
        t_cyc(32'h42000, 2'h3, 2, 30'h10800, 30'h10800, 4'h0, 4'h3);
        t_cyc(32'h42302, 2'h3, 2, 30'h108c1, 30'h108c0, 4'hc, 4'h3);
        t_cyc(32'h42100, 2'h1, 1, 30'h10840, 30'h0, 4'hc, 4'hf);
        t_cyc(32'h42202, 2'h1, 1, 30'h10880, 30'h0, 4'h3, 4'hf);
        t_cyc(32'h2001, 2'h3, 2, 30'h801, 30'h800, 4'he, 4'h1);
        t_cyc(32'h2103, 2'h1, 2, 30'h841, 30'h840, 4'he, 4'h7);
        t_space();
        t_fifo();
        final_report();
    end
endmodule
